// File: src/rtc_pkg.sv
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] RTC_ALARM_FIRST_ADDR  = 4'h7;
  localparam logic [3:0] RTC_ALARM_LAST_ADDR   = 4'hD;
  localparam logic [3:0] RTC_CONTROL_ADDR      = 4'hE;
  localparam logic [3:0] RTC_STATUS_ADDR       = 4'hF;
  localparam int         RTC_ALARM_REGS        = 7;

  // Alarm byte indices, counted from the first alarm register
  localparam logic [2:0] RTC_A1_SEC_IDX        = 3'h0;
  localparam logic [2:0] RTC_A1_MIN_IDX        = 3'h1;
  localparam logic [2:0] RTC_A1_HR_IDX         = 3'h2;
  localparam logic [2:0] RTC_A1_DD_IDX         = 3'h3;
  localparam logic [2:0] RTC_A2_MIN_IDX        = 3'h4;
  localparam logic [2:0] RTC_A2_HR_IDX         = 3'h5;
  localparam logic [2:0] RTC_A2_DD_IDX         = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int         RTC_MASK_BIT          = 7;
  localparam int         RTC_DAYDATE_SEL_BIT   = 6;
  localparam int         RTC_OSF_BIT           = 7;
  localparam int         RTC_A2F_BIT           = 1;
  localparam int         RTC_A1F_BIT           = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RTC_CONTROL_RST       = 8'h18;
  localparam logic [7:0] RTC_STATUS_RST        = 8'h80;
  localparam logic [7:0] RTC_ALARM_RST         = 8'h00;
  localparam logic [7:0] RTC_SECONDS_ZERO      = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         RTC_CLK_PERIOD_NS     = 25;
  localparam int         RTC_OSC_STOP_NS       = 100000;
  localparam int         RTC_OSC_STOP_CYC      = RTC_OSC_STOP_NS / RTC_CLK_PERIOD_NS;
  localparam int         RTC_DIV_W             = 15;
  localparam int         RTC_DIV_4096_BIT      = 2;
  localparam int         RTC_DIV_8192_BIT      = 1;
  localparam int         RTC_DIV_1HZ_BIT       = 14;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTC_RATE_1HZ,
    RTC_RATE_4K,
    RTC_RATE_8K,
    RTC_RATE_32K
  } rtc_rate_t;

  typedef struct packed {
    logic      osc_disable_n;
    logic [1:0] zero_hi;
    rtc_rate_t rate_select;
    logic      irq_routing_select;
    logic      second_alarm_irq_en;
    logic      first_alarm_irq_en;
  } rtc_control_t;

  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] day;
    logic [7:0] date;
  } rtc_time_t;

endpackage : rtc_pkg

// File: src/rtc_alarm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R01 - First alarm all masks set: every second
// R02 - First alarm partial masks: sec/min/hour matching
// R03 - First alarm unmasked: full match incl day/date
// R04 - Second alarm all masked: once per minute
// R05 - Second alarm partial masks: minutes, hours matching
// R06 - Second alarm unmasked: minutes, hours, day/date
// R07 - Oscillator runs while disable bit zero; resets zero
// R08 - Rate codes pick 1Hz/4k/8k/32k square wave
// R09 - Rate select bits reset to ones
// R10 - Routing one: each alarm to own pin
// R11 - Routing zero: square wave on shared pin
// R12 - Second enable gates second flag to pin
// R13 - First enable gates first flag to pin
// R14 - Oscillator stop flag set whenever oscillator stops
// R15 - Stop flag holds until written zero
// R16 - Alarm flags clear by zero only
// R17 - Interrupt pins active low when flag enabled
// R18 - Match tested on once-per-second update
// R19 - Day/date bit chooses day or date
// R20 - Square wave divided from crystal, halts stopped
module rtc_alarm_ctrl
  import rtc_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       osc_clk_in,
  input  wire logic       time_tick_in,
  input  wire rtc_time_t  time_now_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  output logic            osc_run_out,
  output logic            irq_out_first_n_out,
  output logic            square_or_irq_second_n_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A field matches when its mask bit is set or its value agrees
  function automatic logic field_hit(input logic [7:0] alarm, input logic [7:0] now);
    field_hit = alarm[RTC_MASK_BIT] | (alarm[6:0] == now[6:0]);
  endfunction : field_hit

  // Day/date byte compares six bits against day or date
  function automatic logic daydate_hit(input logic [7:0] alarm, input rtc_time_t now);
    logic [7:0] ref_val;
    ref_val = alarm[RTC_DAYDATE_SEL_BIT] ? now.day : now.date; // R19
    daydate_hit = alarm[RTC_MASK_BIT] | (alarm[5:0] == ref_val[5:0]);
  endfunction : daydate_hit

  // A hardware set wins over a software clear in the same cycle
  function automatic logic flag_next(input logic set, input logic cur, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rtc_control_t               ctrl_r;
  rtc_control_t               ctrl_nxt;
  logic                       osf_r;
  logic                       osf_nxt;
  logic                       a1f_r;
  logic                       a1f_nxt;
  logic                       a2f_r;
  logic                       a2f_nxt;
  logic [7:0]                 alarm_r [RTC_ALARM_REGS];
  logic [7:0]                 rdata_nxt;
  logic                       irq_first_n_r;
  logic                       sq_pin_r;
  logic                       sq_pin_nxt;

  // Oscillator path
  logic                       osc_s1_r;
  logic                       osc_s2_r;
  logic                       osc_s3_r;
  logic [RTC_DIV_W-1:0]       div_r;
  logic [11:0]                idle_cnt_r;
  logic                       osc_dead_r;
  logic                       sq_level_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        wr_ctrl    = reg_wr_in && (reg_addr_in == RTC_CONTROL_ADDR);
  wire        wr_status  = reg_wr_in && (reg_addr_in == RTC_STATUS_ADDR);
  wire        in_alarm   = (reg_addr_in >= RTC_ALARM_FIRST_ADDR) &&
                           (reg_addr_in <= RTC_ALARM_LAST_ADDR);
  wire [2:0]  alarm_idx  = 3'(reg_addr_in - RTC_ALARM_FIRST_ADDR);
  wire        wr_alarm   = reg_wr_in && in_alarm;
  wire        osc_on     = ~ctrl_r.osc_disable_n;                    // R07
  wire        osc_rise   = osc_s2_r & ~osc_s3_r;

  // ----------------------------------------------------------------
  // First alarm matching
  // ----------------------------------------------------------------
  wire a1_sec_hit = field_hit(alarm_r[RTC_A1_SEC_IDX], time_now_in.seconds);  // R01 R02
  wire a1_min_hit = field_hit(alarm_r[RTC_A1_MIN_IDX], time_now_in.minutes);  // R02
  wire a1_hr_hit  = field_hit(alarm_r[RTC_A1_HR_IDX],  time_now_in.hours);    // R02
  wire a1_dd_hit  = daydate_hit(alarm_r[RTC_A1_DD_IDX], time_now_in);         // R03
  wire a1_match   = a1_sec_hit & a1_min_hit & a1_hr_hit & a1_dd_hit;

  // ----------------------------------------------------------------
  // Second alarm matching
  // ----------------------------------------------------------------
  // Second alarm has no seconds byte, so it only fires at second zero
  wire a2_sec_hit = (time_now_in.seconds == RTC_SECONDS_ZERO);                // R04
  wire a2_min_hit = field_hit(alarm_r[RTC_A2_MIN_IDX], time_now_in.minutes);  // R05
  wire a2_hr_hit  = field_hit(alarm_r[RTC_A2_HR_IDX],  time_now_in.hours);    // R05
  wire a2_dd_hit  = daydate_hit(alarm_r[RTC_A2_DD_IDX], time_now_in);         // R06
  wire a2_match   = a2_sec_hit & a2_min_hit & a2_hr_hit & a2_dd_hit;

  wire a1_set   = time_tick_in & a1_match;                                  // R18
  wire a2_set   = time_tick_in & a2_match;                                  // R18
  wire osf_set  = ~osc_on | osc_dead_r;                                     // R14

  // ----------------------------------------------------------------
  // Next-state values
  // ----------------------------------------------------------------
  // Software clear strobes: a zero written to a flag bit
  wire clr_osf = wr_status & ~reg_wdata_in[RTC_OSF_BIT];
  wire clr_a1f = wr_status & ~reg_wdata_in[RTC_A1F_BIT];
  wire clr_a2f = wr_status & ~reg_wdata_in[RTC_A2F_BIT];

  assign osf_nxt = flag_next(osf_set, osf_r, clr_osf);                      // R15
  assign a1f_nxt = flag_next(a1_set,  a1f_r, clr_a1f);                      // R16
  assign a2f_nxt = flag_next(a2_set,  a2f_r, clr_a2f);                      // R16

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------

  // Bits 6 and 5 of control always read zero
  assign ctrl_nxt = wr_ctrl ? rtc_control_t'({reg_wdata_in[7], 2'b00, reg_wdata_in[4:0]})
                            : ctrl_r;

  // ----------------------------------------------------------------
  // Interrupt pins
  // ----------------------------------------------------------------
  wire a1_irq   = a1f_r & ctrl_r.first_alarm_irq_en;                        // R13
  wire a2_irq   = a2f_r & ctrl_r.second_alarm_irq_en;                       // R12
  wire a2_on_first     = a2_irq & ~ctrl_r.irq_routing_select;               // R12
  wire irq_first_nxt_n = ~(a1_irq | a2_on_first);                           // R17

  // ----------------------------------------------------------------
  // Square wave selection
  // ----------------------------------------------------------------
  // Taps of the divided crystal clock
  wire tap_1hz = div_r[RTC_DIV_1HZ_BIT];
  wire tap_4k  = div_r[RTC_DIV_4096_BIT];
  wire tap_8k  = div_r[RTC_DIV_8192_BIT];
  wire tap_32k = osc_s3_r;

  logic sq_sel;
  always_comb begin
    unique case (ctrl_r.rate_select)                                        // R08
      RTC_RATE_1HZ: sq_sel = tap_1hz;
      RTC_RATE_4K:  sq_sel = tap_4k;
      RTC_RATE_8K:  sq_sel = tap_8k;
      RTC_RATE_32K: sq_sel = tap_32k;
    endcase
  end

  // Routing picks the second alarm or the square wave for the shared pin
  assign sq_pin_nxt = ctrl_r.irq_routing_select ? ~a2_irq : sq_level_r;     // R10 R11

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] ctrl_word   = ctrl_r;
  wire [7:0] status_word = {osf_r, 5'b00000, a2f_r, a1f_r};

  always_comb begin
    rdata_nxt = 8'h00;
    if (in_alarm) begin
      rdata_nxt = alarm_r[alarm_idx];
    end else if (reg_addr_in == RTC_CONTROL_ADDR) begin
      rdata_nxt = ctrl_word;
    end else if (reg_addr_in == RTC_STATUS_ADDR) begin
      rdata_nxt = status_word;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_r <= RTC_CONTROL_RST;                                            // R07 R09 R11 R12 R13
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Stop flag comes up set, so software can tell the time is not valid
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osf_r <= RTC_STATUS_RST[RTC_OSF_BIT];                                 // R14
    end else begin
      osf_r <= osf_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      a1f_r <= 1'b0;
    end else begin
      a1f_r <= a1f_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      a2f_r <= 1'b0;
    end else begin
      a2f_r <= a2f_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < RTC_ALARM_REGS; i++) begin
        alarm_r[i] <= RTC_ALARM_RST;
      end
    end else if (wr_alarm) begin
      alarm_r[alarm_idx] <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // Pins idle high so no false interrupt leaves reset
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_first_n_r <= 1'b1;
    end else begin
      irq_first_n_r <= irq_first_nxt_n;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sq_pin_r <= 1'b1;
    end else begin
      sq_pin_r <= sq_pin_nxt;
    end
  end

  assign irq_out_first_n_out        = irq_first_n_r;
  assign square_or_irq_second_n_out = sq_pin_r;
  assign osc_run_out                = osc_on;

  // ----------------------------------------------------------------
  // Crystal clock sampling and division
  // ----------------------------------------------------------------
  // Third stage feeds the edge detector and the 32k square wave tap, never the first stage
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osc_s1_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_clk_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osc_s2_r <= 1'b0;
    end else begin
      osc_s2_r <= osc_s1_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osc_s3_r <= 1'b0;
    end else begin
      osc_s3_r <= osc_s2_r;
    end
  end

  // Divider advances only on crystal edges while enabled
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      div_r <= '0;
    end else if (osc_on && osc_rise) begin
      div_r <= div_r + 1'b1;                                                // R20
    end
  end

  // Square level freezes when the crystal stops
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sq_level_r <= 1'b0;
    end else if (osc_on && !osc_dead_r) begin
      sq_level_r <= sq_sel;                                                 // R20
    end
  end

  // A missing crystal edge for the stop window counts as a stop
  // Counter parks at the window end instead of wrapping
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      idle_cnt_r <= '0;
    end else if (osc_rise) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != 12'(RTC_OSC_STOP_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osc_dead_r <= 1'b0;
    end else if (osc_rise) begin
      osc_dead_r <= 1'b0;
    end else if (idle_cnt_r == 12'(RTC_OSC_STOP_CYC)) begin
      osc_dead_r <= 1'b1;                                                   // R14
    end
  end

endmodule : rtc_alarm_ctrl

`default_nettype wire

// File: dv/rtc_xtal_model.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_xtal_model #(parameter int HALF_NS = 100) (
  input  wire logic run_in,
  output logic      osc_out
);
  // Odd start offset keeps the crystal out of phase with the core clock
  initial begin
    osc_out = 1'b0;
    #7;
    forever #(HALF_NS) osc_out = run_in ? ~osc_out : 1'b0;
  end
endmodule : rtc_xtal_model
`default_nettype wire

// File: dv/rtc_alarm_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_ctrl_checker
  import rtc_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       osc_clk_in,
  input wire logic       time_tick_in,
  input wire rtc_time_t  time_now_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       osc_run_out,
  input wire logic       irq_out_first_n_out,
  input wire logic       square_or_irq_second_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic ctl_wr = reg_wr_in && reg_addr_in == RTC_CONTROL_ADDR;
  wire logic st_wr  = reg_wr_in && reg_addr_in == RTC_STATUS_ADDR;
  wire logic wd_hi  = reg_wdata_in[7];
  chk_osc_run_ctrl:
    assert property (ctl_wr |=> osc_run_out == !$past(wd_hi))
    else $error("osc run level wrong after control write");
  chk_ctrl_readback:
    assert property (ctl_wr ##1 (reg_addr_in == RTC_CONTROL_ADDR && !reg_wr_in)
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h9F))
    else $error("control readback wrong");
  chk_reset_idle:
    assert property ($fell(sys_rst_in) |-> irq_out_first_n_out
      && square_or_irq_second_n_out && osc_run_out)
    else $error("outputs not idle after reset");
  chk_flag_clear_irq:
    assert property (st_wr && reg_wdata_in[1:0] == 2'h0 && !time_tick_in
      |-> ##2 irq_out_first_n_out)
    else $error("first irq pin low after flags cleared");
  chk_irq_enable_off:
    assert property (ctl_wr && reg_wdata_in[1:0] == 2'h0 |-> ##2 irq_out_first_n_out)
    else $error("first irq pin low with enables off");
  chk_shared_route_irq:
    assert property (ctl_wr && reg_wdata_in[2:1] == 2'h2
      |-> ##2 square_or_irq_second_n_out)
    else $error("second irq pin low with its enable off");
  chk_irq_cause:
    assert property ($fell(irq_out_first_n_out) |-> $past(time_tick_in, 2) || $past(ctl_wr, 2))
    else $error("first irq pin fell without tick or enable");
  chk_osf_while_stopped:
    assert property (!osc_run_out [*3] ##0 reg_addr_in == RTC_STATUS_ADDR |=> reg_rdata_out[7])
    else $error("stop flag clear while oscillator disabled");
  chk_status_reserved:
    assert property (reg_addr_in == RTC_STATUS_ADDR |=> reg_rdata_out[6:2] == 5'h00)
    else $error("status unused bits not zero");
  cover property (!irq_out_first_n_out);
  cover property ($rose(square_or_irq_second_n_out));
  cover property (!osc_run_out);
endmodule : rtc_alarm_ctrl_checker
bind rtc_alarm_ctrl rtc_alarm_ctrl_checker u_chk (.core_clk_in, .sys_rst_in, .osc_clk_in,
  .time_tick_in, .time_now_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
  .osc_run_out, .irq_out_first_n_out, .square_or_irq_second_n_out);
`default_nettype wire

// File: dv/test_rtc_alarm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_rtc_alarm_ctrl
  import rtc_pkg::*;
;
  typedef struct packed {
    logic [31:0] a1;
    logic [23:0] a2;
    logic [7:0]  sec;
    logic [1:0]  flags;
  } rtc_row_t;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic       osc;
  logic       tick = 1'b0;
  rtc_time_t  tnow = 40'h0015080321;
  logic [3:0] addr = 4'h0;
  logic       wr   = 1'b0;
  logic [7:0] wd   = 8'h00;
  logic [7:0] rd;
  logic       run, irq1_n, irq2_n, p;
  logic [7:0] v;
  int         miscompares = 0, cmp_count = 0, cyc = 0, n;
  // Crystal is 8 core cycles a period: 640 cycles give 80, 20, 10 edges at 32k, /4, /8
  int         sq_exp [5] = '{0, 10, 20, 80, 0};
  rtc_row_t   rows [11] = '{
    '{32'h80808080, 24'h808080, 8'h30, 2'h1}, '{32'h80808080, 24'h808080, 8'h00, 2'h3},
    '{32'h00808080, 24'h158080, 8'h00, 2'h3}, '{32'h01808080, 24'h168080, 8'h00, 2'h0},
    '{32'h00158080, 24'h150880, 8'h00, 2'h3}, '{32'h00168080, 24'h150980, 8'h00, 2'h0},
    '{32'h00150880, 24'h150821, 8'h00, 2'h3}, '{32'h00150980, 24'h150843, 8'h00, 2'h2},
    '{32'h00150821, 24'h150803, 8'h00, 2'h1}, '{32'h00150843, 24'h150844, 8'h00, 2'h1},
    '{32'h00150803, 24'h150821, 8'h00, 2'h2}};
  always #12.5 clk = ~clk;
  rtc_xtal_model u_xtal (.run_in(run), .osc_out(osc));
  rtc_alarm_ctrl dut (.core_clk_in(clk), .sys_rst_in(rst), .osc_clk_in(osc),
    .time_tick_in(tick), .time_now_in(tnow), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wd), .reg_rdata_out(rd), .osc_run_out(run),
    .irq_out_first_n_out(irq1_n), .square_or_irq_second_n_out(irq2_n));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : put
  task automatic get(input logic [3:0] a, output logic [7:0] q);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    q = rd;
  endtask : get
  task automatic pulse(input logic [7:0] s);
    @(negedge clk);
    tnow.seconds = s;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    @(negedge clk);
  endtask : pulse
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    put(RTC_CONTROL_ADDR, 8'h07);
    foreach (rows[i]) begin
      put(RTC_STATUS_ADDR, 8'h00);
      for (int b = 0; b < RTC_ALARM_REGS; b++)
        put(RTC_ALARM_FIRST_ADDR + 4'(b), 8'({rows[i].a1, rows[i].a2} >> (8 * (6 - b))));
      pulse(rows[i].sec);
      get(RTC_STATUS_ADDR, v);
      chk(v & 8'h03, {6'h00, rows[i].flags});
      chk({7'h00, irq1_n}, {7'h00, !rows[i].flags[0]});
      chk({7'h00, irq2_n}, {7'h00, !rows[i].flags[1]});
    end
    // Second reset in mid-run brings every field back to power-up values
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    get(RTC_CONTROL_ADDR, v);
    chk(v, 8'h18);
    get(RTC_STATUS_ADDR, v);
    chk(v, 8'h80);
    put(RTC_STATUS_ADDR, 8'hFF);
    get(RTC_STATUS_ADDR, v);
    chk(v, 8'h80);
    put(RTC_STATUS_ADDR, 8'h7F);
    get(RTC_STATUS_ADDR, v);
    chk(v, 8'h00);
    get(4'h3, v);
    chk(v, 8'h00);
    put(RTC_CONTROL_ADDR, 8'hFF);
    get(RTC_CONTROL_ADDR, v);
    chk({7'h00, run}, 8'h00);
    get(RTC_STATUS_ADDR, v);
    chk(v & 8'h80, 8'h80);
    put(RTC_CONTROL_ADDR, 8'h01);
    put(RTC_STATUS_ADDR, 8'h00);
    for (int b = 0; b < RTC_ALARM_REGS; b++)
      put(RTC_ALARM_FIRST_ADDR + 4'(b), 8'h80);
    pulse(8'h00);
    chk({7'h00, irq1_n}, 8'h00);
    put(RTC_CONTROL_ADDR, 8'h00);
    @(negedge clk);
    chk({7'h00, irq1_n}, 8'h01);
    put(RTC_CONTROL_ADDR, 8'h02);
    @(negedge clk);
    chk({7'h00, irq1_n}, 8'h00);
    put(RTC_CONTROL_ADDR, 8'h04);
    @(negedge clk);
    chk({6'h00, irq2_n, irq1_n}, 8'h03);
    put(RTC_STATUS_ADDR, 8'h01);
    get(RTC_STATUS_ADDR, v);
    chk(v & 8'h03, 8'h01);
    for (int r = 0; r < 5; r++) begin
      put(RTC_CONTROL_ADDR, r == 4 ? 8'h98 : 8'(r << 3));
      repeat (16) @(negedge clk);
      n = 0;
      p = irq2_n;
      repeat (640) begin
        @(negedge clk);
        n += int'(irq2_n && !p);
        p = irq2_n;
      end
      // One edge of slack for where the window cuts the wave
      chk(8'(n) - 8'(sq_exp[r]) + 8'h01 <= 8'h02 ? 8'(sq_exp[r]) : 8'(n), 8'(sq_exp[r]));
    end
    report_and_stop();
  end
endmodule : test_rtc_alarm_ctrl
`default_nettype wire
